// ==== hdl/rate_guard_and_diag_counters.sv ====
// rate guard, diagnostic event counters and sync-loss capture
`timescale 1ns/1ps
`include "guard_defines.svh"
module rate_guard_and_diag_counters import guard_pkg::*; #(
	parameter int WINDOW_CYCLES = `RG_WINDOW_S * `RG_CLK_HZ,
	parameter int LINK_DEPTH = 4096,
	parameter int DUMP_WORDS = 200
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic raw_trigger,
	input wire logic proc_trigger,
	input wire logic hw_inhibit,
	input wire logic sw_inhibit,
	input wire logic proc_limit_load,
	input wire logic [15:0] proc_limit_in,
	input wire logic hv_on_cmd,
	input wire logic hv_off_cmd,
	input wire logic mode_cmd_valid,
	input wire fe_mode_type mode_cmd,
	input wire logic [15:0] cal_event_limit,
	input wire logic [15:0] diag_event_limit,
	input wire logic hk_xfer,
	input wire event_pulses_type events,
	input wire logic counter_rpt_req,
	input wire logic periodic_rpt_en,
	input wire logic periodic_timing_pulse,
	input wire logic link_word_valid,
	input wire logic [15:0] link_word,
	input wire logic link_sync_lost,
	input wire logic [1:0] event_size_sel,
	input wire logic sync_auto_set,
	input wire logic sync_auto_value,
	input wire logic sync_rpt_req,
	output logic hv_enable,
	output logic hk_hv_lost,
	output fe_mode_type fe_mode,
	output logic sync_auto_en,
	output report_word_type rpt
);
	localparam int PW = $clog2(LINK_DEPTH);
	// ------------------------------------------------------------
	// window timer and ratemeters
	// ------------------------------------------------------------
	logic [31:0] win_cnt_reg;
	logic win_start, raw_trip, proc_trip;
	logic [15:0] proc_limit_reg;
	assign win_start = (win_cnt_reg == 32'(WINDOW_CYCLES - 1));
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			win_cnt_reg <= '0;
		end else if (clk_en) begin
			win_cnt_reg <= win_start ? '0 : win_cnt_reg + 32'h0000_0001;
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			proc_limit_reg <= `RG_PROC_LIMIT_RST;
		end else if (clk_en && proc_limit_load) begin
			proc_limit_reg <= proc_limit_in;
		end
	end
	window_ratemeter #(.W(17)) raw_meter (
		.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
		.active(1'b1),
		.win_start(win_start), .pulse(raw_trigger), .limit(`RG_RAW_LIMIT), .trip(raw_trip)
	);
	// fed before any thinning filter, so its setting cannot matter
	window_ratemeter #(.W(17)) proc_meter (
		.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
		.active(fe_mode == MODE_NORMAL),
		.win_start(win_start), .pulse(proc_trigger), .limit(proc_limit_reg), .trip(proc_trip)
	);
	// ------------------------------------------------------------
	// high voltage and housekeeping status
	// ------------------------------------------------------------
	logic kill, hv_lost_reg;
	assign kill = (raw_trip && !hw_inhibit) || (proc_trip && !sw_inhibit);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hv_enable <= 1'b0;
		end else if (clk_en) begin
			if (kill || hv_off_cmd) begin
				hv_enable <= 1'b0;
			end else if (hv_on_cmd) begin
				hv_enable <= 1'b1; // only the partner turns it back on
			end
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hv_lost_reg <= 1'b0;
			hk_hv_lost <= 1'b0;
		end else if (clk_en) begin
			if (kill && hv_enable) begin
				hv_lost_reg <= 1'b1;
			end else if (hk_xfer) begin
				hv_lost_reg <= 1'b0;
			end
			if (hk_xfer) begin
				hk_hv_lost <= hv_lost_reg || (kill && hv_enable);
			end
		end
	end
	// ------------------------------------------------------------
	// front end mode
	// ------------------------------------------------------------
	logic [15:0] mode_ev_reg;
	logic mode_done;
	assign mode_done = proc_trigger && (((fe_mode == MODE_CALIB) &&
		(mode_ev_reg + 16'h0001 >= cal_event_limit)) || ((fe_mode == MODE_DIAG) &&
		(mode_ev_reg + 16'h0001 >= diag_event_limit)));
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			fe_mode <= MODE_SETUP;
			mode_ev_reg <= '0;
		end else if (clk_en) begin
			if (mode_cmd_valid) begin
				fe_mode <= mode_cmd;
				mode_ev_reg <= '0;
			end else begin
				case (fe_mode)
					MODE_CALIB, MODE_DIAG: begin
						if (mode_done) begin
							fe_mode <= MODE_SETUP;
							mode_ev_reg <= '0;
						end else if (proc_trigger) begin
							mode_ev_reg <= mode_ev_reg + 16'h0001;
						end
					end
					default: mode_ev_reg <= '0;
				endcase
			end
		end
	end
	// ------------------------------------------------------------
	// event counters
	// ------------------------------------------------------------
	logic [15:0] cnt_reg [`RG_NUM_CNT], snap_reg [`RG_NUM_CNT];
	logic snap_now;
	generate
		for (genvar i = 0; i < `RG_NUM_CNT; i++) begin : g_cnt
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					cnt_reg[i] <= '0;
					snap_reg[i] <= '0;
				end else if (clk_en) begin
					if (snap_now) begin
						snap_reg[i] <= cnt_reg[i];
						cnt_reg[i] <= events[i] ? 16'h0001 : 16'h0000;
					end else if (events[i] && cnt_reg[i] != `RG_CNT_MAX) begin
						cnt_reg[i] <= cnt_reg[i] + 16'h0001;
					end
				end
			end
		end
	endgenerate
	// ------------------------------------------------------------
	// link input buffer and sync-loss capture
	// ------------------------------------------------------------
	logic [15:0] link_mem [LINK_DEPTH], cap_mem [DUMP_WORDS];
	logic [PW-1:0] wr_ptr_reg, loss_idx_reg, dump_off_reg;
	logic [PW:0] fill_reg, cap_fill_reg;
	logic [7:0] cap_len_reg, cap_i_reg;
	logic cap_busy_reg, sync_auto_req;
	// writes pause while copying so the dump is coherent; words lost
	always_ff @(posedge core_clk) begin
		if (clk_en && link_word_valid && !cap_busy_reg) begin
			link_mem[wr_ptr_reg] <= link_word;
		end
		if (clk_en && cap_busy_reg) begin
			cap_mem[cap_i_reg] <= link_mem[PW'(dump_off_reg + PW'(cap_i_reg))];
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_reg <= '0;
			fill_reg <= '0;
		end else if (clk_en && link_word_valid && !cap_busy_reg) begin
			wr_ptr_reg <= wr_ptr_reg + PW'(1);
			if (fill_reg != (PW+1)'(LINK_DEPTH)) begin
				fill_reg <= fill_reg + (PW+1)'(1);
			end
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cap_busy_reg <= 1'b0;
			cap_len_reg <= '0;
			cap_i_reg <= '0;
			cap_fill_reg <= '0;
			loss_idx_reg <= '0;
			dump_off_reg <= '0;
		end else if (clk_en) begin
			if (link_sync_lost && !cap_busy_reg) begin
				cap_busy_reg <= 1'b1;
				cap_i_reg <= '0;
				cap_len_reg <= '0;
				cap_fill_reg <= fill_reg;
				loss_idx_reg <= wr_ptr_reg;
				dump_off_reg <= (wr_ptr_reg >= PW'(`RG_DUMP_HALF)) ?
					wr_ptr_reg - PW'(`RG_DUMP_HALF) : '0;
			end else if (cap_busy_reg) begin
				cap_i_reg <= cap_i_reg + 8'h01;
				cap_len_reg <= (cap_fill_reg == '0) ? 8'h00 : cap_i_reg + 8'h01;
				if (cap_i_reg == 8'(DUMP_WORDS - 1) ||
					(PW+1)'(cap_i_reg) + (PW+1)'(1) >= cap_fill_reg) begin
					cap_busy_reg <= 1'b0;
				end
			end
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sync_auto_en <= 1'b0;
		end else if (clk_en && sync_auto_set) begin
			sync_auto_en <= sync_auto_value;
		end
	end
	assign sync_auto_req = link_sync_lost && !cap_busy_reg && sync_auto_en;
	// ------------------------------------------------------------
	// report sequencer
	// ------------------------------------------------------------
	rpt_state_type rpt_state_reg;
	logic [7:0] idx_reg;
	logic cnt_pend_reg, sync_pend_reg, cnt_req, sync_go;
	logic [15:0] diag_word, sync_word;
	assign cnt_req = counter_rpt_req || (periodic_rpt_en && periodic_timing_pulse);
	assign snap_now = clk_en && (rpt_state_reg == RPT_IDLE) && (cnt_pend_reg || cnt_req);
	assign sync_go = (rpt_state_reg == RPT_IDLE) && !cnt_pend_reg && !cnt_req &&
		sync_pend_reg && !cap_busy_reg;
	always_comb begin
		if (idx_reg == `RG_MK0_POS) begin
			diag_word = `RG_MK0_VAL;
		end else if (idx_reg < `RG_MK1_POS) begin
			diag_word = snap_reg[5'(idx_reg - 8'h01)];
		end else if (idx_reg == `RG_MK1_POS) begin
			diag_word = `RG_MK1_VAL;
		end else if (idx_reg < `RG_MK2_POS) begin
			diag_word = snap_reg[5'(idx_reg - 8'h02)];
		end else if (idx_reg == `RG_MK2_POS) begin
			diag_word = `RG_MK2_VAL;
		end else if (idx_reg < `RG_MK3_POS) begin
			diag_word = snap_reg[5'(idx_reg - 8'h03)];
		end else if (idx_reg == `RG_MK3_POS) begin
			diag_word = `RG_MK3_VAL;
		end else if (idx_reg < `RG_MK4_POS) begin
			diag_word = snap_reg[5'(idx_reg - 8'h04)];
		end else begin
			diag_word = `RG_MK4_VAL;
		end
	end
	always_comb begin
		if (idx_reg == 8'h00) begin
			sync_word = (event_size_sel == 2'h0) ? `RG_EVSZ_A :
				(event_size_sel == 2'h1) ? `RG_EVSZ_B : `RG_EVSZ_C;
		end else if (idx_reg == 8'h01) begin
			sync_word = 16'(cap_fill_reg);
		end else if (idx_reg == 8'h02) begin
			sync_word = 16'(loss_idx_reg);
		end else if (idx_reg == `RG_SYNC_HDR_LAST) begin
			sync_word = 16'(dump_off_reg);
		end else begin
			sync_word = cap_mem[idx_reg - 8'h04];
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_pend_reg <= 1'b0;
			sync_pend_reg <= 1'b0;
		end else if (clk_en) begin
			cnt_pend_reg <= (cnt_pend_reg || cnt_req) && !snap_now;
			sync_pend_reg <= sync_pend_reg && !sync_go || sync_rpt_req || sync_auto_req;
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rpt_state_reg <= RPT_IDLE;
			idx_reg <= '0;
			rpt <= '0;
		end else if (clk_en) begin
			rpt <= '0;
			case (rpt_state_reg)
				RPT_IDLE: begin
					idx_reg <= '0;
					if (snap_now) begin
						rpt_state_reg <= RPT_COUNTERS;
					end else if (sync_go) begin
						rpt_state_reg <= RPT_SYNC;
					end
				end
				RPT_COUNTERS: begin
					rpt <= '{valid: 1'b1, last: idx_reg == `RG_DIAG_LAST,
						sync_kind: 1'b0, data: diag_word};
					idx_reg <= idx_reg + 8'h01;
					if (idx_reg == `RG_DIAG_LAST) begin
						rpt_state_reg <= RPT_IDLE;
					end
				end
				RPT_SYNC: begin
					rpt <= '{valid: 1'b1, last: idx_reg == `RG_SYNC_HDR_LAST + cap_len_reg,
						sync_kind: 1'b1, data: sync_word};
					idx_reg <= idx_reg + 8'h01;
					if (idx_reg == `RG_SYNC_HDR_LAST + cap_len_reg) begin
						rpt_state_reg <= RPT_IDLE;
					end
				end
				default: rpt_state_reg <= RPT_IDLE;
			endcase
		end
	end
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_cnt_start;
		clk_en && snap_now;
	endsequence
	sequence s_first_word;
		clk_en ##1 clk_en ##1 rpt.valid;
	endsequence
	AST_RAW_KILL: assert property (clk_en && raw_trip && !hw_inhibit |=> !hv_enable)
		else $error("raw trip left hv on");
	AST_INHIBITS: assert property (clk_en && hv_enable && hw_inhibit && sw_inhibit &&
		!hv_off_cmd |=> hv_enable)
		else $error("inhibited ratemeter removed hv");
	AST_NO_RECOVER: assert property (!hv_enable && !(clk_en && hv_on_cmd) |=> !hv_enable)
		else $error("hv returned without command");
	AST_PROC_ONLY_NORMAL: assert property (proc_trip |-> $past(fe_mode) == MODE_NORMAL)
		else $error("processed ratemeter active outside normal");
	AST_HK_REPORT: assert property (clk_en && hk_xfer && hv_lost_reg |=> hk_hv_lost)
		else $error("hv loss not reported");
	AST_CLEAR: assert property (s_cnt_start |=> cnt_reg[0] <= 16'h0001)
		else $error("counter not cleared by report");
	AST_MARKER0: assert property (s_cnt_start ##0 s_first_word |->
		rpt.data == `RG_MK0_VAL && !rpt.sync_kind)
		else $error("report word 0 is not the marker");
	AST_SYNC_EMPTY: assert property (rpt_state_reg == RPT_SYNC && cap_len_reg == 8'h00 &&
		idx_reg == `RG_SYNC_HDR_LAST && clk_en |=> rpt.last)
		else $error("empty capture report too long");
	AST_MODE_END: assert property (clk_en && mode_done && !mode_cmd_valid |=>
		fe_mode == MODE_SETUP)
		else $error("self terminating mode did not end");
endmodule

// ==== hdl/guard_defines.svh ====
// constants for the rate guard and diagnostic counter block
`ifndef GUARD_DEFINES_SVH
`define GUARD_DEFINES_SVH
`define RG_CLK_HZ 20_000_000
`define RG_WINDOW_S 8
`define RG_RAW_LIMIT 16'hFFFF
`define RG_PROC_LIMIT_RST 16'h7FFF
`define RG_CNT_MAX 16'hFFFF
`define RG_NUM_CNT 21
`define RG_DIAG_LAST 8'h19
`define RG_MK0_POS 8'h00
`define RG_MK1_POS 8'h08
`define RG_MK2_POS 8'h0D
`define RG_MK3_POS 8'h13
`define RG_MK4_POS 8'h19
`define RG_MK0_VAL 16'h1111
`define RG_MK1_VAL 16'h2222
`define RG_MK2_VAL 16'h3333
`define RG_MK3_VAL 16'h4444
`define RG_MK4_VAL 16'h5555
`define RG_EVSZ_A 16'h0006
`define RG_EVSZ_B 16'h0025
`define RG_EVSZ_C 16'h002B
`define RG_SYNC_HDR_LAST 8'h03
`define RG_DUMP_MAX 8'hC8
`define RG_DUMP_HALF 12'h064
`endif

// ==== hdl/guard_pkg.sv ====
// types shared by the rate guard and diagnostic counter block
package guard_pkg;
	typedef enum logic [2:0] {
		MODE_SETUP = 3'b000,
		MODE_NORMAL = 3'b001,
		MODE_CALIB = 3'b010,
		MODE_DIAG = 3'b011,
		MODE_SAFE = 3'b100
	} fe_mode_type;
	typedef enum logic [1:0] {
		RPT_IDLE = 2'b00,
		RPT_COUNTERS = 2'b01,
		RPT_SYNC = 2'b10
	} rpt_state_type;
	// bit 0 of tc is report word 1, upward in word order
	typedef struct packed {
		logic [4:0] fast;
		logic [4:0] slow;
		logic [3:0] conv;
		logic [6:0] tc;
	} event_pulses_type;
	typedef struct packed {
		logic valid;
		logic last;
		logic sync_kind;
		logic [15:0] data;
	} report_word_type;
endpackage

// ==== hdl/window_ratemeter.sv ====
// windowed trigger ratemeter with saturating count and trip pulse
`timescale 1ns/1ps
`include "guard_defines.svh"
module window_ratemeter import guard_pkg::*; #(
	parameter int W = 17
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic active,
	input wire logic win_start,
	input wire logic pulse,
	input wire logic [15:0] limit,
	output logic trip
);
	logic [W-1:0] cnt_reg;
	logic fired_reg;
	logic over;
	assign over = pulse && active && (cnt_reg >= W'(limit)) && !fired_reg;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else if (clk_en) begin
			if (win_start || !active) begin
				cnt_reg <= (pulse && active) ? W'(1) : '0;
			end else if (pulse && !(&cnt_reg)) begin
				cnt_reg <= cnt_reg + W'(1);
			end
		end
	end
	// one trip per window is enough, hv stays off anyway
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			fired_reg <= 1'b0;
			trip <= 1'b0;
		end else if (clk_en) begin
			trip <= over;
			if (win_start || !active) begin
				fired_reg <= 1'b0;
			end else if (over) begin
				fired_reg <= 1'b1;
			end
		end
	end
	AST_TRIP_CAUSE: assert property (@(posedge core_clk) disable iff (!nrst)
		clk_en && over |=> trip)
		else $error("ratemeter missed an overflow");
endmodule

// ==== tb/dpu_model.sv ====
// behavioural model of the data processing unit that commands the front end
`timescale 1ns/1ps
module dpu_model import guard_pkg::*; (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic hk_req,
	input wire logic mode_req,
	input wire fe_mode_type mode_req_value,
	input wire logic hk_hv_lost,
	output logic hk_xfer,
	output logic mode_cmd_valid,
	output fe_mode_type mode_cmd
);
	logic lost_seen_reg;
	// --------------------------------
	// commands, changed off the sampling edge
	// --------------------------------
	always @(negedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hk_xfer <= 1'b0;
			mode_cmd_valid <= 1'b0;
			mode_cmd <= MODE_SETUP;
			lost_seen_reg <= 1'b0;
		end else begin
			hk_xfer <= hk_req;
			lost_seen_reg <= hk_hv_lost;
			if (hk_hv_lost && !lost_seen_reg) begin
				// voltage loss reported: answer once with safe
				mode_cmd_valid <= 1'b1;
				mode_cmd <= MODE_SAFE;
			end else begin
				mode_cmd_valid <= mode_req;
				mode_cmd <= mode_req ? mode_req_value : MODE_SETUP;
			end
		end
	end
endmodule

// ==== tb/rate_guard_and_diag_counters_test.sv ====
// self-checking bench for the rate guard and diagnostic counter block
`timescale 1ns/1ps
module rate_guard_and_diag_counters_test import guard_pkg::*; ();
	// window just above the raw limit so one trip fits in the run
	localparam int WIN = 65600;
	localparam logic [15:0] SZ [4] = '{16'h0006, 16'h0025, 16'h002B, 16'h002B};
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic clk_en = 1'b1, hw_inhibit = 1'b0, sw_inhibit = 1'b0, hv_off_cmd = 1'b0;
	logic raw_trigger = 1'b0, proc_trigger = 1'b0, proc_limit_load = 1'b0, hv_on_cmd = 1'b0;
	logic [15:0] proc_limit_in = 16'h0000, link_word = 16'h0000;
	logic [15:0] cal_event_limit = 16'h0003, diag_event_limit = 16'h0003;
	logic counter_rpt_req = 1'b0, periodic_rpt_en = 1'b0, periodic_timing_pulse = 1'b0;
	logic link_word_valid = 1'b0, link_sync_lost = 1'b0, sync_rpt_req = 1'b0;
	logic sync_auto_set = 1'b0, sync_auto_value = 1'b0, hk_req = 1'b0, mode_req = 1'b0;
	logic [1:0] event_size_sel = 2'b00;
	fe_mode_type mode_req_value = MODE_SETUP;
	event_pulses_type events = '0;
	logic hk_xfer, mode_cmd_valid, hv_enable, hk_hv_lost, sync_auto_en;
	fe_mode_type mode_cmd, fe_mode;
	report_word_type rpt;
	logic [15:0] words [$];
	logic [15:0] exp_w [26];
	int n_errors = 0;
	int n_checks = 0;
	int cycles = 0;

	// --------------------------------
	// clock, instances, hang guard
	// --------------------------------
	always #25 core_clk = ~core_clk;

	rate_guard_and_diag_counters #(.WINDOW_CYCLES(WIN), .LINK_DEPTH(256), .DUMP_WORDS(200))
	i_rate_guard_and_diag_counters (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
		.raw_trigger(raw_trigger), .proc_trigger(proc_trigger), .hw_inhibit(hw_inhibit),
		.sw_inhibit(sw_inhibit), .proc_limit_load(proc_limit_load),
		.proc_limit_in(proc_limit_in), .hv_on_cmd(hv_on_cmd), .hv_off_cmd(hv_off_cmd),
		.mode_cmd_valid(mode_cmd_valid), .mode_cmd(mode_cmd),
		.cal_event_limit(cal_event_limit), .diag_event_limit(diag_event_limit),
		.hk_xfer(hk_xfer), .events(events), .counter_rpt_req(counter_rpt_req),
		.periodic_rpt_en(periodic_rpt_en), .periodic_timing_pulse(periodic_timing_pulse),
		.link_word_valid(link_word_valid), .link_word(link_word),
		.link_sync_lost(link_sync_lost), .event_size_sel(event_size_sel),
		.sync_auto_set(sync_auto_set), .sync_auto_value(sync_auto_value),
		.sync_rpt_req(sync_rpt_req), .hv_enable(hv_enable), .hk_hv_lost(hk_hv_lost),
		.fe_mode(fe_mode), .sync_auto_en(sync_auto_en), .rpt(rpt));

	dpu_model i_dpu_model (.core_clk(core_clk), .nrst(nrst), .hk_req(hk_req),
		.mode_req(mode_req), .mode_req_value(mode_req_value), .hk_hv_lost(hk_hv_lost),
		.hk_xfer(hk_xfer), .mode_cmd_valid(mode_cmd_valid), .mode_cmd(mode_cmd));

	// run is about 66100 cycles, ceiling leaves margin
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 75000) begin
			n_errors++;
			$display("Error at %0t: timeout got %h expected %h", $time, cycles, 75000);
			give_verdict();
		end
	end

	// --------------------------------
	// shared tasks
	// --------------------------------
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// one-cycle pulse, then a quiet cycle so the next pulse is distinct
	task automatic hit(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask

	task automatic mode_go(input fe_mode_type m);
		mode_req_value <= m;
		mode_req <= 1'b1;
		cyc(1);
		mode_req <= 1'b0;
		cyc(4);
		chk({13'h0, fe_mode}, {13'h0, m});
	endtask

	// collect one report; capture copy may take up to 200 cycles first
	task automatic get_rpt(input logic kind);
		int guard;
		logic last;
		words = {};
		guard = 0;
		while (rpt.valid !== 1'b1 && guard < 400) begin
			cyc(1);
			guard++;
		end
		do begin
			words.push_back(rpt.data);
			chk({15'h0, rpt.sync_kind}, {15'h0, kind});
			last = rpt.last;
			cyc(1);
			guard++;
		end while (last !== 1'b1 && rpt.valid === 1'b1 && guard < 400);
		chk({15'h0, last}, 16'h0001);
	endtask

	task automatic counter_rpt_check(input logic [15:0] fill);
		foreach (exp_w[i]) exp_w[i] = fill;
		exp_w[0] = 16'h1111;
		exp_w[8] = 16'h2222;
		exp_w[13] = 16'h3333;
		exp_w[19] = 16'h4444;
		exp_w[25] = 16'h5555;
		if (fill == 16'h0000 && periodic_rpt_en) begin
			exp_w[1] = 16'h0001;
			exp_w[24] = 16'h0001;
		end
		get_rpt(1'b0);
		chk(16'(words.size()), 16'h001A);
		foreach (exp_w[i]) chk(words[i], exp_w[i]);
	endtask

	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_reset();
		chk({15'h0, hv_enable}, 16'h0000);
		chk({13'h0, fe_mode}, {13'h0, MODE_SETUP});
		chk({15'h0, sync_auto_en}, 16'h0000);
		chk({15'h0, rpt.valid}, 16'h0000);
	endtask

	// raw trip in setup mode, counters driven to saturation meanwhile
	task automatic t_raw();
		hit(hv_on_cmd);
		cyc(2);
		chk({15'h0, hv_enable}, 16'h0001);
		raw_trigger = 1'b1;
		events = '1;
		cyc(65535);
		raw_trigger = 1'b0;
		events = '0;
		cyc(4);
		chk({15'h0, hv_enable}, 16'h0001);
		hit(raw_trigger);
		cyc(2);
		chk({15'h0, hv_enable}, 16'h0000);
		cyc(300);
		chk({15'h0, hv_enable}, 16'h0000);
		hk_req <= 1'b1;
		cyc(1);
		hk_req <= 1'b0;
		cyc(4);
		chk({15'h0, hk_hv_lost}, 16'h0001);
		cyc(5);
		chk({13'h0, fe_mode}, {13'h0, MODE_SAFE});
	endtask

	task automatic t_counters();
		hit(counter_rpt_req);
		counter_rpt_check(16'hFFFF);
		hit(counter_rpt_req);
		counter_rpt_check(16'h0000);
		periodic_rpt_en = 1'b1;
		events.tc[0] = 1'b1;
		events.fast[4] = 1'b1;
		cyc(1);
		events = '0;
		hit(periodic_timing_pulse);
		counter_rpt_check(16'h0000);
		periodic_rpt_en = 1'b0;
	endtask

	task automatic t_sync_empty();
		for (int s = 0; s < 4; s++) begin
			event_size_sel = 2'(s);
			hit(sync_rpt_req);
			get_rpt(1'b1);
			chk(16'(words.size()), 16'h0004);
			chk(words[0], SZ[s]);
			chk(words[1] | words[2] | words[3], 16'h0000);
		end
	endtask

	task automatic t_sync_loss();
		sync_auto_value = 1'b1;
		hit(sync_auto_set);
		chk({15'h0, sync_auto_en}, 16'h0001);
		event_size_sel = 2'd1;
		for (int i = 0; i < 10; i++) begin
			link_word = 16'h0A00 + 16'(i);
			link_word_valid = 1'b1;
			cyc(1);
		end
		link_word_valid = 1'b0;
		link_word = ~link_word;
		hit(link_sync_lost);
		get_rpt(1'b1);
		chk(16'(words.size()), 16'h000E);
		chk(words[0], 16'h0025);
		chk(words[1], 16'h000A);
		chk(words[2], 16'h000A);
		chk(words[3], 16'h0000);
		for (int i = 0; i < 10; i++) chk(words[4 + i], 16'h0A00 + 16'(i));
	endtask

	task automatic t_proc();
		proc_limit_in = 16'h0004;
		hit(proc_limit_load);
		hit(hv_on_cmd);
		mode_go(MODE_SETUP);
		proc_trigger = 1'b1;
		cyc(6);
		proc_trigger = 1'b0;
		cyc(3);
		chk({15'h0, hv_enable}, 16'h0001);
		// both inhibits up: the overflow trips but hv must stay
		hw_inhibit = 1'b1;
		sw_inhibit = 1'b1;
		mode_go(MODE_NORMAL);
		proc_trigger = 1'b1;
		cyc(5);
		proc_trigger = 1'b0;
		cyc(3);
		chk({15'h0, hv_enable}, 16'h0001);
		// leaving normal clears the meter, so the next window is fresh
		sw_inhibit = 1'b0;
		mode_go(MODE_SETUP);
		mode_go(MODE_NORMAL);
		proc_trigger = 1'b1;
		cyc(4);
		proc_trigger = 1'b0;
		cyc(3);
		chk({15'h0, hv_enable}, 16'h0001);
		hit(proc_trigger);
		cyc(2);
		chk({15'h0, hv_enable}, 16'h0000);
		hw_inhibit = 1'b0;
	endtask

	// clock enable low: an on command is lost, hv stays off
	task automatic t_freeze();
		clk_en = 1'b0;
		hit(hv_on_cmd);
		cyc(2);
		clk_en = 1'b1;
		chk({15'h0, hv_enable}, 16'h0000);
	endtask

	// self-ending modes: limit 3, third processed trigger reverts
	task automatic t_mode(input fe_mode_type m);
		mode_go(m);
		proc_trigger = 1'b1;
		cyc(2);
		proc_trigger = 1'b0;
		cyc(3);
		chk({13'h0, fe_mode}, {13'h0, m});
		hit(proc_trigger);
		cyc(2);
		chk({13'h0, fe_mode}, {13'h0, MODE_SETUP});
	endtask

	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		cyc(12);
		nrst = 1'b1;
		t_reset();
		t_raw();
		t_counters();
		t_sync_empty();
		t_sync_loss();
		t_proc();
		t_freeze();
		t_mode(MODE_CALIB);
		t_mode(MODE_DIAG);
		give_verdict();
	end
endmodule
